// ### flash_operation_control_test.sv
// Self-checking bench for the flash operation control block
`timescale 1ns/1ps
module flash_operation_control_test;
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0;
    logic [7:0] o_reg_rdata;
    logic [7:0] dly = 8'h01;
    logic o_flash_req, o_flash_abort, o_busy, i_flash_done, i_flash_fail, fail_cfg = 1'b0;
    logic [1:0] o_flash_op, seen_op;
    logic [15:0] o_flash_sector, seen_sec;
    int mismatches = 0, n_tests = 0, cycles = 0, nreq = 0, nabort = 0, status = 0;
    always #10 i_sys_clk = ~i_sys_clk;
    focx_flash_operation_control #(.TIMEOUT_CYCLES(16)) dut (.i_sys_clk, .i_srst, .i_reg_addr,
        .i_reg_wdata, .i_reg_wr, .o_reg_rdata, .o_flash_req, .o_flash_op, .o_flash_sector,
        .o_flash_abort, .i_flash_done, .i_flash_fail, .o_busy);
    focx_flash_model model (.i_sys_clk, .i_req(o_flash_req), .i_abort(o_flash_abort),
        .i_delay(dly), .i_fail_cfg(fail_cfg), .o_done(i_flash_done), .o_fail(i_flash_fail));
    ////////////////////////////////////////
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (o_flash_req === 1'b1) begin
            nreq <= nreq + 1;
            seen_op <= o_flash_op;
            seen_sec <= o_flash_sector;
        end
        if (o_flash_abort === 1'b1) nabort <= nabort + 1;
        if (cycles == 8000) begin
            mismatches = mismatches + 1;
            conclude();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        @(posedge i_sys_clk);
        #1 d = o_reg_rdata;
    endtask
    // Kind 0 runs to the end, 1 stops it midway, 2 lets the array stall to timeout
    task automatic run(input logic [3:0] m, input logic [7:0] key, input int kind);
        logic [15:0] sec;
        logic [7:0] r;
        int n0, a0;
        bit ok;
        sec = 16'($urandom);
        n0 = nreq;
        a0 = nabort;
        ok = key == focx_pkg::FOCX_USER_KEY && m inside {4'h5, 4'ha, 4'h6};
        dly <= (kind > 0) ? 8'h00 : 8'($urandom_range(1, 8));
        fail_cfg <= 1'($urandom);
        wr(focx_pkg::FOCX_ADDR_SECTOR_HIGH, sec[15:8]);
        wr(focx_pkg::FOCX_ADDR_SECTOR_LOW, sec[7:0]);
        wr(focx_pkg::FOCX_ADDR_USER_KEY, key);
        wr(focx_pkg::FOCX_ADDR_OP_CONTROL, {m, 4'h1});
        if (kind == 1) begin
            repeat (3) @(posedge i_sys_clk);
            wr(focx_pkg::FOCX_ADDR_OP_CONTROL, {m, 4'h0});
        end
        repeat (3) @(posedge i_sys_clk);
        #1;
        for (int i = 0; i < 40 && o_busy !== 1'b0; i++) @(posedge i_sys_clk) #1;
        chk(16'(o_busy), 16'h0000);
        if (ok && m == 4'ha && kind != 1) status = (kind == 2) ? 1 : int'(fail_cfg);
        chk(16'(nreq - n0), 16'(ok));
        if (ok) chk(seen_op, (m == 4'h5) ? 2'h1 : (m == 4'ha) ? 2'h2 : 2'h3);
        if (ok) chk(seen_sec, sec);
        chk(16'(nabort - a0), 16'(ok && kind == 1));
        rd(focx_pkg::FOCX_ADDR_OP_CONTROL, r);
        chk(r & 8'hf9, {m, 1'(status), 2'h0, !ok && kind != 1});
        rd(focx_pkg::FOCX_ADDR_SECTOR_HIGH, r);
        chk(r, sec[15:8]);
        rd(focx_pkg::FOCX_ADDR_SECTOR_LOW, r);
        chk(r, sec[7:0]);
        rd(focx_pkg::FOCX_ADDR_USER_KEY, r);
        chk(r, key);
        wr(focx_pkg::FOCX_ADDR_OP_CONTROL, 8'h00);
    endtask
    task automatic conclude();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        logic [7:0] r;
        void'($urandom(77));
        repeat (8) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        rd(focx_pkg::FOCX_ADDR_OP_CONTROL, r);
        chk(r, focx_pkg::FOCX_RESET_VALUE);
        rd(8'h0c, r);
        chk(r, 8'h00);
        for (int m = 0; m < 16; m++) run(4'(m), focx_pkg::FOCX_USER_KEY, 0);
        for (int i = 0; i < 6; i++) run(4'ha, focx_pkg::FOCX_USER_KEY, 0);
        run(4'h5, 8'($urandom_range(0, 164)), 0);
        run(4'ha, focx_pkg::FOCX_USER_KEY, 2);
        run(4'ha, focx_pkg::FOCX_USER_KEY, 1);
        run(4'h7, focx_pkg::FOCX_USER_KEY, 1);
        conclude();
    end
endmodule
bind focx_flash_operation_control focx_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) mon (
    .i_sys_clk, .i_srst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .o_reg_rdata, .o_flash_req,
    .o_flash_op, .o_flash_sector, .o_flash_abort, .i_flash_done, .i_flash_fail, .o_busy);

// ### focx_flash_model.sv
// Behavioural flash array answering launch requests
`timescale 1ns/1ps
module focx_flash_model (
    input wire logic i_sys_clk,
    input wire logic i_req,
    input wire logic i_abort,
    input wire logic [7:0] i_delay,
    input wire logic i_fail_cfg,
    output logic o_done = 1'b0,
    output logic o_fail = 1'b0
);
    int cnt_reg = 0;
    // Zero delay never answers; fail toggles outside done, as it is meaningless there
    always @(posedge i_sys_clk) begin
        o_done <= 1'b0;
        o_fail <= ~o_fail;
        if (i_req) cnt_reg <= i_delay;
        else if (i_abort) cnt_reg <= 0;
        else if (cnt_reg > 1) cnt_reg <= cnt_reg - 1;
        else if (cnt_reg == 1) begin
            cnt_reg <= 0;
            o_done <= 1'b1;
            o_fail <= i_fail_cfg;
        end
    end
endmodule

// ### focx_flash_operation_control.sv
// Flash operation control: registers, sequencing and flash array handshake
`timescale 1ns/1ps
module focx_flash_operation_control #(
    parameter int TIMEOUT_CYCLES = focx_pkg::FOCX_TIMEOUT_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    output logic [7:0] o_reg_rdata,
    // Flash array side
    output logic o_flash_req,
    output logic [1:0] o_flash_op,
    output logic [15:0] o_flash_sector,
    output logic o_flash_abort,
    input wire logic i_flash_done,
    input wire logic i_flash_fail,
    output logic o_busy
);
    ////////////////////////////////////////////////////////////////////////////
    logic [3:0] mode_reg;
    logic start_reg;
    logic status_reg;
    logic [7:0] sector_high_reg;
    logic [7:0] sector_low_reg;
    logic [7:0] user_key_reg;
    logic [7:0] rdata_reg;
    logic req_reg;
    logic abort_reg;
    logic [1:0] op_reg;
    logic [15:0] sector_reg;
    logic [15:0] timer_reg;
    logic busy_reg;
    focx_pkg::focx_state_t state_reg;
    focx_pkg::focx_state_t state_next;
    focx_pkg::focx_op_t decoded_op;

    // Address match shared by the write strobes and the read select
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    wire wr_ctrl = i_reg_wr && addr_hit(i_reg_addr, focx_pkg::FOCX_ADDR_OP_CONTROL);
    wire wr_high = i_reg_wr && addr_hit(i_reg_addr, focx_pkg::FOCX_ADDR_SECTOR_HIGH);
    wire wr_low = i_reg_wr && addr_hit(i_reg_addr, focx_pkg::FOCX_ADDR_SECTOR_LOW);
    wire wr_key = i_reg_wr && addr_hit(i_reg_addr, focx_pkg::FOCX_ADDR_USER_KEY);
    wire rd_ctrl = addr_hit(i_reg_addr, focx_pkg::FOCX_ADDR_OP_CONTROL);
    wire rd_high = addr_hit(i_reg_addr, focx_pkg::FOCX_ADDR_SECTOR_HIGH);
    wire rd_low = addr_hit(i_reg_addr, focx_pkg::FOCX_ADDR_SECTOR_LOW);
    wire rd_key = addr_hit(i_reg_addr, focx_pkg::FOCX_ADDR_USER_KEY);
    wire key_ok = (user_key_reg == focx_pkg::FOCX_USER_KEY); // [R06]
    wire [15:0] sector_ptr = {sector_high_reg, sector_low_reg}; // [R07]
    wire [3:0] wr_mode = i_reg_wdata[focx_pkg::FOCX_MODE_MSB:focx_pkg::FOCX_MODE_LSB];
    wire wr_start = i_reg_wdata[focx_pkg::FOCX_START_BIT];
    wire op_valid = (decoded_op != focx_pkg::FOCX_OP_NONE);
    wire timed_out = (timer_reg == 16'(TIMEOUT_CYCLES - 1));
    wire active = (state_reg != focx_pkg::FOCX_IDLE);
    // Software clearing the start bit mid-flight aborts [R04]
    wire stop_req = wr_ctrl && !wr_start && active;
    wire finished = (state_reg == focx_pkg::FOCX_WAIT) && (i_flash_done || timed_out);
    // Launch needs start set, valid mode and unlocked key [R01] [R06]
    wire launch = (state_reg == focx_pkg::FOCX_IDLE) && start_reg && op_valid && key_ok;
    wire erase_end = finished && (op_reg == 2'(focx_pkg::FOCX_OP_ERASE));

    focx_mode_decode u_decode (
        .i_mode(mode_reg),
        .o_op(decoded_op)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            focx_pkg::FOCX_IDLE: begin
                if (launch) begin
                    state_next = focx_pkg::FOCX_ISSUE; // [R01]
                end
            end
            focx_pkg::FOCX_ISSUE: begin
                state_next = stop_req ? focx_pkg::FOCX_IDLE : focx_pkg::FOCX_WAIT; // [R04]
            end
            focx_pkg::FOCX_WAIT: begin
                if (finished || stop_req) begin
                    state_next = focx_pkg::FOCX_IDLE; // [R02] [R04]
                end
            end
            // Spare code of the two-bit state falls back to idle
            default: begin
                state_next = focx_pkg::FOCX_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_reg <= focx_pkg::FOCX_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Busy taken from the next state, so it tracks the state register exactly
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next != focx_pkg::FOCX_IDLE);
        end
    end

    // Mode frozen while running, so the status matches the launched op
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            mode_reg <= 4'h0;
        end else if (wr_ctrl && !active) begin
            mode_reg <= wr_mode; // [R03]
        end
    end

    // Finish wins over a late software set, never loses the clear
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            start_reg <= 1'b0;
        end else if (finished || stop_req) begin
            start_reg <= 1'b0; // [R02] [R04]
        end else if (wr_ctrl) begin
            start_reg <= wr_start; // [R01]
        end
    end

    // Stalled erase counts as failed; abort keeps the last result
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            status_reg <= 1'b0;
        end else if (erase_end) begin
            status_reg <= i_flash_fail || !i_flash_done; // [R05]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            sector_high_reg <= focx_pkg::FOCX_RESET_VALUE;
        end else if (wr_high) begin
            sector_high_reg <= i_reg_wdata; // [R07]
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            sector_low_reg <= focx_pkg::FOCX_RESET_VALUE;
        end else if (wr_low) begin
            sector_low_reg <= i_reg_wdata; // [R07]
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            user_key_reg <= focx_pkg::FOCX_RESET_VALUE;
        end else if (wr_key) begin
            user_key_reg <= i_reg_wdata; // [R06]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timeout guards against an array that never answers
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || state_reg != focx_pkg::FOCX_WAIT) begin
            timer_reg <= 16'h0000;
        end else begin
            timer_reg <= timer_reg + 16'h0001;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            req_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else begin
            req_reg <= launch; // [R01]
            abort_reg <= stop_req; // [R04]
        end
    end

    // Op and sector hold after launch so the array may read them late
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            op_reg <= 2'(focx_pkg::FOCX_OP_NONE);
            sector_reg <= 16'h0000;
        end else if (launch) begin
            op_reg <= 2'(decoded_op); // [R03]
            sector_reg <= sector_ptr; // [R07]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bits 2:1 read as zero
    wire [7:0] ctrl_view = {mode_reg, status_reg, 2'h0, start_reg};
    // Unmapped addresses read as zero
    wire [7:0] rdata_next = rd_ctrl ? ctrl_view :
                            rd_high ? sector_high_reg :
                            rd_low ? sector_low_reg :
                            rd_key ? user_key_reg :
                            8'h00;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_flash_req = req_reg;
    assign o_flash_op = op_reg;
    assign o_flash_sector = sector_reg;
    assign o_flash_abort = abort_reg;
    assign o_busy = busy_reg;
endmodule

// ### focx_mode_decode.sv
// Mode field decoder for the flash operation control block
`timescale 1ns/1ps
module focx_mode_decode (
    input wire logic [3:0] i_mode,
    output focx_pkg::focx_op_t o_op
);
    // Any other code selects nothing [R03]
    assign o_op = (i_mode == focx_pkg::FOCX_MODE_PROGRAM) ? focx_pkg::FOCX_OP_PROGRAM :
                  (i_mode == focx_pkg::FOCX_MODE_ERASE) ? focx_pkg::FOCX_OP_ERASE :
                  (i_mode == focx_pkg::FOCX_MODE_LOCK) ? focx_pkg::FOCX_OP_LOCK :
                  focx_pkg::FOCX_OP_NONE;
endmodule

// ### focx_monitor.sv
// Port checker for flash operation control
`timescale 1ns/1ps
module focx_monitor #(parameter int TIMEOUT_CYCLES = 16) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_flash_req,
    input wire logic [1:0] o_flash_op,
    input wire logic [15:0] o_flash_sector,
    input wire logic o_flash_abort,
    input wire logic i_flash_done,
    input wire logic i_flash_fail,
    input wire logic o_busy
);
    logic [7:0] key_reg;
    logic [7:0] hi_reg;
    logic [7:0] lo_reg;
    int cnt_reg = 0;
    wire ctl_wr = i_reg_wr && i_reg_addr == focx_pkg::FOCX_ADDR_OP_CONTROL;
    wire key_ok = key_reg == focx_pkg::FOCX_USER_KEY;
    wire [15:0] shadow_sec = {hi_reg, lo_reg};
    wire stop_wr = ctl_wr && !i_reg_wdata[0] && o_busy && !i_flash_done;
    // Shadows of the key and sector register writes, so launch checks need no design internals
    always_ff @(posedge i_sys_clk) begin
        cnt_reg <= (o_busy && !i_srst) ? cnt_reg + 1 : 0;
        if (i_reg_wr && i_reg_addr == focx_pkg::FOCX_ADDR_USER_KEY) key_reg <= i_reg_wdata;
        if (i_reg_wr && i_reg_addr == focx_pkg::FOCX_ADDR_SECTOR_HIGH) hi_reg <= i_reg_wdata;
        if (i_reg_wr && i_reg_addr == focx_pkg::FOCX_ADDR_SECTOR_LOW) lo_reg <= i_reg_wdata;
    end
    ////////////////////////////////////////
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    AST_REQ_PULSE: assert property (o_flash_req |=> !o_flash_req)
        else $error("launch pulse too long");
    AST_REQ_FROM_IDLE: assert property ($rose(o_busy) |-> o_flash_req)
        else $error("busy without launch");
    AST_REQ_OP: assert property (o_flash_req |-> o_flash_op != 2'h0)
        else $error("launch with no operation");
    AST_REQ_KEY: assert property (o_flash_req |-> $past(key_ok))
        else $error("launch without key");
    AST_SECTOR: assert property (o_flash_req |-> o_flash_sector == $past(shadow_sec))
        else $error("sector pointer wrong");
    AST_DONE_ENDS: assert property (o_busy && !o_flash_req && i_flash_done |=> !o_busy)
        else $error("finish not taken");
    AST_BOUNDED: assert property (cnt_reg <= TIMEOUT_CYCLES + 4)
        else $error("operation never ends");
    AST_ABORT: assert property (stop_wr |-> ##[1:2] o_flash_abort)
        else $error("stop not signalled");
    AST_ABORT_IDLE: assert property (o_flash_abort |-> ##[0:1] !o_busy)
        else $error("busy after stop");
    cover property (o_flash_req && o_flash_op == 2'h2);
    cover property (o_flash_abort);
    cover property (cnt_reg == TIMEOUT_CYCLES);
endmodule

// ### focx_pkg.sv
// Package for the flash operation control block: offsets, fields, codes, timing
//
// Summary of operation
// (R01) Writing start bit launches selected mode
// (R02) Start bit self-clears when operation finishes
// (R03) Mode 0101 program, 1010 erase, 0110 lock
// (R04) Start bit zero stops or withholds operation
// (R05) Status bit 3 reports sector erase failure
// (R06) Operations need user key 10100101 loaded
// (R07) Sector pointer is high and low bytes
package focx_pkg;
    localparam logic [7:0] FOCX_ADDR_SECTOR_HIGH = 8'h08;
    localparam logic [7:0] FOCX_ADDR_SECTOR_LOW = 8'h09;
    localparam logic [7:0] FOCX_ADDR_USER_KEY = 8'h0a;
    localparam logic [7:0] FOCX_ADDR_OP_CONTROL = 8'h0b;

    localparam int FOCX_START_BIT = 0;
    localparam int FOCX_STATUS_BIT = 3;
    localparam int FOCX_MODE_LSB = 4;
    localparam int FOCX_MODE_MSB = 7;

    localparam logic [3:0] FOCX_MODE_PROGRAM = 4'h5;
    localparam logic [3:0] FOCX_MODE_ERASE = 4'ha;
    localparam logic [3:0] FOCX_MODE_LOCK = 4'h6;

    localparam logic [7:0] FOCX_USER_KEY = 8'ha5;
    localparam logic [7:0] FOCX_RESET_VALUE = 8'h00;

    // Default cap on how long the array may take, in cycles
    localparam int FOCX_TIMEOUT_CYCLES = 4096;

    typedef enum logic [1:0] {
        FOCX_OP_NONE,
        FOCX_OP_PROGRAM,
        FOCX_OP_ERASE,
        FOCX_OP_LOCK
    } focx_op_t;

    typedef enum logic [1:0] {
        FOCX_IDLE,
        FOCX_ISSUE,
        FOCX_WAIT
    } focx_state_t;
endpackage
